// [src/adc_port_io_ext_mux.sv]
`timescale 1ns/1ps
// Digital pin ports and external multiplexer addressing of the converter

// Summary of operation
// - Pin synchronizers stay off until a bus cycle addresses a port value register.
// - Port A read returns live pin level for bits set as inputs.
// - Port A read returns output latch for bits set as outputs.
// - Mux mode forces port A bits 2..0 to outputs driving mux address.
// - Mux mode reads of port A bits 2..0 return mux address latch.
// - Two 8-bit port value registers; port A is bidirectional.
// - Port B is an 8-bit input-only port without direction register.
// - Port A value register keeps its contents through reset; port B's is cleared.
// - Direction bit one makes pin output; zero makes it input.
// - Reserved control bits read zero; writes to them do nothing.
// - One to four external eight-way muxes give up to 32 channels.
// - Mux address derived from channel number of each command executed in mux mode.
// - Channel number also selects which of four muxed inputs is converted.
// - Mux mode follows the select bit in control register zero.
// - Sixteen direct channels; mux mode turns three into address outputs.
// - w even 0-14, x odd 1-15, y even 16-30, z odd 17-31.
// - In stop mode port A and direction registers hold and are read-only.
module adc_port_io_ext_mux (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    // Module bus slave
    input  wire logic                    bus_sel,
    input  wire logic                    bus_wr,
    input  wire logic [3:0]              bus_addr,
    input  wire logic [7:0]              bus_wdata,
    output logic      [7:0]              bus_rdata,
    output logic                         bus_ack,
    input  wire logic                    stop_mode,
    // Pins
    input  wire logic [7:0]              port_a_pins_in,
    output logic      [7:0]              port_a_pins_out,
    output logic      [7:0]              port_a_pins_oe,
    input  wire logic [7:0]              port_b_pins_in,
    output logic      [2:0]              mux_addr_out,
    // Conversion command from the queue logic
    input  wire logic                    cmd_start,
    input  wire logic [5:0]              cmd_channel,
    output logic                         ext_mux_mode,
    output logic      [1:0]              analog_route,
    output logic      [3:0]              analog_in_sel,
    output logic                         route_is_muxed
);
    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire        acc_a   = bus_sel && (bus_addr == adc_port_pkg::OFF_PORT_A);
    wire        acc_b   = bus_sel && (bus_addr == adc_port_pkg::OFF_PORT_B);
    wire        acc_dir = bus_sel && (bus_addr == adc_port_pkg::OFF_DIR_A);
    wire        acc_c0  = bus_sel && (bus_addr == adc_port_pkg::OFF_CTRL0);
    wire        wr_ok   = bus_wr && !stop_mode;
    wire        wr_a    = acc_a && wr_ok;
    wire        wr_dir  = acc_dir && wr_ok;
    wire        wr_c0   = acc_c0 && wr_ok;

    logic [7:0] dir_r;
    logic [7:0] ctrl0_r;
    logic [2:0] muxa_r;
    logic [1:0] route_r;
    logic [7:0] port_a_latch;
    logic [7:0] rdata_r;
    logic       ack_r;
    adc_port_pkg::sync_state_t sync_r;
    logic [7:0] a_meta_r;
    logic [7:0] a_sync_r;
    logic [7:0] b_meta_r;
    logic [7:0] b_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // Output latch of port A, not reset
    port_latch u_port_a_latch (
        .clk_sys (clk_sys),
        .wr_en   (wr_a),
        .wr_data (bus_wdata),
        .q       (port_a_latch)
    );

    ////////////////////////////////////////////////////////////////////////
    // Direction and control
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dir_r   <= adc_port_pkg::DIR_A_RESET;
            ctrl0_r <= adc_port_pkg::CTRL0_RESET;
        end else begin
            if (wr_dir) begin
                dir_r <= bus_wdata & adc_port_pkg::DIR_A_IMPL;
            end
            if (wr_c0) begin
                ctrl0_r <= bus_wdata & adc_port_pkg::CTRL0_IMPL;
            end
        end
    end

    assign ext_mux_mode = ctrl0_r[adc_port_pkg::CTRL0_MUX_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Synchronizer enable: pins are only sampled once a port read or write has
    // been seen, which keeps mid-level analog inputs off the digital path
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync_r <= adc_port_pkg::SYNC_OFF;
        end else begin
            case (sync_r)
                adc_port_pkg::SYNC_OFF: begin
                    if (acc_a || acc_b) begin
                        sync_r <= adc_port_pkg::SYNC_ON;
                    end
                end
                adc_port_pkg::SYNC_ON: sync_r <= adc_port_pkg::SYNC_ON;
                default: sync_r <= adc_port_pkg::SYNC_OFF;
            endcase
        end
    end

    wire sync_en = (sync_r == adc_port_pkg::SYNC_ON) || acc_a || acc_b;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            a_meta_r <= 8'h00;
            a_sync_r <= 8'h00;
            b_meta_r <= 8'h00;
            b_sync_r <= 8'h00;
        end else if (sync_en) begin
            a_meta_r <= port_a_pins_in;
            a_sync_r <= a_meta_r;
            b_meta_r <= port_b_pins_in;
            b_sync_r <= b_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mux address and analog route, loaded at command start
    function automatic logic [1:0] route_of(input logic [5:0] ch);
        route_of = {ch[adc_port_pkg::CHAN_GRP_LSB], ch[0]};
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            muxa_r  <= adc_port_pkg::MUXA_RESET;
            route_r <= adc_port_pkg::ROUTE_RESET;
        end else if (cmd_start && ext_mux_mode) begin
            muxa_r  <= cmd_channel[3:1];
            route_r <= route_of(cmd_channel);
        end
    end

    assign mux_addr_out   = muxa_r;
    assign analog_route   = route_r;
    assign route_is_muxed = ext_mux_mode;
    // One-hot select of the port B inputs w, x, y, z in mux mode
    assign analog_in_sel  = ext_mux_mode ? (4'h1 << route_r) : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Pin drive
    wire [7:0] force_m = ext_mux_mode ? 8'h07 : 8'h00;
    wire [7:0] mux_byte = {5'h00, muxa_r};

    assign port_a_pins_oe  = dir_r | force_m;
    assign port_a_pins_out = (port_a_latch & ~force_m) | (mux_byte & force_m);

    ////////////////////////////////////////////////////////////////////////
    // Read data
    wire [7:0] a_base = (a_sync_r & ~dir_r) | (port_a_latch & dir_r);
    wire [7:0] a_read = (a_base & ~force_m) | (mux_byte & force_m);
    wire [7:0] rd_mux = acc_a   ? a_read  :
                        acc_b   ? b_sync_r :
                        acc_dir ? dir_r   :
                        acc_c0  ? ctrl0_r : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
            ack_r   <= 1'b0;
        end else begin
            rdata_r <= (bus_sel && !bus_wr) ? rd_mux : 8'h00;
            ack_r   <= bus_sel && !ack_r;
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_ack   = ack_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // The port A latch is unknown until first written; chk_out_read compares
    // read data with it whenever bit 7 is an output outside mux mode, written or not
    chk_mux_force_oe: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ext_mux_mode |-> (port_a_pins_oe[2:0] == 3'h7))
        else $error("mux mode did not force low pins to output");

    chk_dir_oe_map: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_mux_mode |-> (port_a_pins_oe == dir_r))
        else $error("output enable does not follow direction");

    chk_dir_reserved: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(wr_dir) |->
        (dir_r == ($past(bus_wdata) & adc_port_pkg::DIR_A_IMPL)))
        else $error("direction write not taken");

    chk_stop_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (stop_mode && bus_wr) |=> ($stable(dir_r) && $stable(ctrl0_r)))
        else $error("register changed in stop mode");

    chk_addr_load: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cmd_start && ext_mux_mode) |=>
        (mux_addr_out == $past(cmd_channel[3:1])))
        else $error("mux address not loaded from command");

    chk_addr_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !cmd_start |=> $stable(muxa_r))
        else $error("mux address changed without command");

    chk_route_map: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cmd_start && ext_mux_mode) |=> (analog_route ==
        {$past(cmd_channel[4]), $past(cmd_channel[0])}))
        else $error("wrong analog route");

    chk_sync_off: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!sync_en) |=> $stable(a_sync_r) && $stable(b_sync_r))
        else $error("synchronizer ran while disabled");

    chk_mux_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_a && !bus_wr && ext_mux_mode) |=>
        (bus_rdata[2:0] == $past(muxa_r)))
        else $error("mux read returned wrong address");

    chk_out_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_a && !bus_wr && !ext_mux_mode && dir_r[7]) |=>
        (bus_rdata[7] == $past(port_a_latch[7])))
        else $error("output bit read not from latch");

    chk_in_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_a && !bus_wr && !ext_mux_mode && !dir_r[7]) |=>
        (bus_rdata[7] == $past(a_sync_r[7])))
        else $error("input bit read not from pin");

    chk_port_b_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_b && !bus_wr) |=> (bus_rdata == $past(b_sync_r)))
        else $error("port B read not from pins");

    chk_stop_latch: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (stop_mode && bus_wr) |=> $stable(port_a_latch))
        else $error("port A latch changed in stop mode");

    chk_dir_rsvd: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_dir && !bus_wr) |=>
        ((bus_rdata & ~adc_port_pkg::DIR_A_IMPL) == 8'h00))
        else $error("reserved direction bit read as one");

    chk_ctrl_rsvd: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_c0 && !bus_wr) |=>
        ((bus_rdata & ~adc_port_pkg::CTRL0_IMPL) == 8'h00))
        else $error("reserved control bit read as one");

    chk_sel_direct: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_mux_mode |-> (analog_in_sel == 4'h0))
        else $error("muxed input selected outside mux mode");

    chk_sel_onehot: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ext_mux_mode |-> $onehot(analog_in_sel))
        else $error("muxed input select not one-hot");

    chk_muxed_flag: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        route_is_muxed == ext_mux_mode)
        else $error("muxed route flag disagrees with mode");

    chk_mux_pins_drive: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ext_mux_mode |-> (port_a_pins_out[2:0] == mux_addr_out))
        else $error("low pins do not carry mux address");

    chk_upper_oe: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ext_mux_mode |-> (port_a_pins_oe[7:3] == dir_r[7:3]))
        else $error("mux mode disturbed upper pin directions");

    chk_addr_direct: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (cmd_start && !ext_mux_mode) |=> $stable(muxa_r))
        else $error("mux address loaded outside mux mode");

    chk_route_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !cmd_start |=> $stable(route_r))
        else $error("route changed without command");

    chk_sync_start: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (acc_a || acc_b) |=> (sync_r == adc_port_pkg::SYNC_ON))
        else $error("port access did not enable synchronizer");

    chk_sync_stays: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (sync_r == adc_port_pkg::SYNC_ON) |=>
        (sync_r == adc_port_pkg::SYNC_ON))
        else $error("synchronizer switched off again");

    chk_ack_pulse: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        bus_ack |=> !bus_ack)
        else $error("bus ack longer than one cycle");

    chk_ack_follow: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (bus_sel && !bus_ack) |=> bus_ack)
        else $error("bus cycle not acknowledged");

    chk_rd_idle: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!bus_sel || bus_wr) |=> (bus_rdata == 8'h00))
        else $error("read data not zero outside a read");
endmodule

// [src/adc_port_pkg.sv]
// Constants for the converter pin port and external multiplexer logic
package adc_port_pkg;
    localparam int          PORT_W          = 8;
    localparam int          ADDR_W          = 4;
    localparam int          MUXA_W          = 3;
    localparam int          CHAN_W          = 6;
    // Register word offsets on the module bus
    localparam logic [3:0]  OFF_PORT_A      = 4'h0;
    localparam logic [3:0]  OFF_PORT_B      = 4'h1;
    localparam logic [3:0]  OFF_DIR_A       = 4'h2;
    localparam logic [3:0]  OFF_CTRL0       = 4'h3;
    // Field positions
    localparam int          CTRL0_MUX_BIT   = 7;
    localparam int          CHAN_GRP_LSB    = 4;
    // Values after reset and masks of implemented bits
    localparam logic [7:0]  DIR_A_RESET     = 8'h00;
    localparam logic [7:0]  CTRL0_RESET     = 8'h00;
    localparam logic [7:0]  DIR_A_IMPL      = 8'hff;
    localparam logic [7:0]  CTRL0_IMPL      = 8'h80;
    localparam logic [2:0]  MUXA_RESET      = 3'h0;
    localparam logic [1:0]  ROUTE_RESET     = 2'h0;
    // Analog route codes: w, x, y, z; direct and muxed channel counts
    localparam logic [1:0]  ROUTE_W         = 2'h0;
    localparam logic [1:0]  ROUTE_X         = 2'h1;
    localparam logic [1:0]  ROUTE_Y         = 2'h2;
    localparam logic [1:0]  ROUTE_Z         = 2'h3;
    localparam int          CH_DIRECT_MAX   = 16;
    localparam int          CH_MUXED_MAX    = 32;

    typedef enum logic [1:0] {
        SYNC_OFF  = 2'b00,
        SYNC_ON   = 2'b01
    } sync_state_t;
endpackage

// [src/port_latch.sv]
`timescale 1ns/1ps
// Byte latch with no reset, so its contents survive a device reset
module port_latch (
    input  wire logic       clk_sys,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule

// [tb/pin_model.sv]
// Pin-side model: outside levels seen on port A and port B
`timescale 1ns/1ps
module pin_model (
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe,
    input  wire logic [7:0] a_ext,
    input  wire logic [7:0] b_ext,
    output logic      [7:0] a_pin,
    output logic      [7:0] b_pin
);
    // A driven pin shows its driver, an undriven one the outside level
    assign a_pin = (a_out & a_oe) | (a_ext & ~a_oe);
    assign b_pin = b_ext;
endmodule

// [tb/test_adc_port_io_ext_mux.sv]
// Register and pin tests of the converter pin port block
`timescale 1ns/1ps
module test_adc_port_io_ext_mux;
    logic       clk_sys, reset_n, bus_sel, bus_wr, stop_mode, cmd_start;
    logic [3:0] bus_addr, analog_in_sel;
    logic [7:0] bus_wdata, bus_rdata, a_out, a_oe, a_pin, b_pin, a_ext;
    logic [7:0] b_ext;
    logic       bus_ack, ext_mux_mode, route_is_muxed;
    logic [2:0] mux_addr_out;
    logic [1:0] analog_route;
    logic [5:0] cmd_channel;
    int         n_errors, n_checks, c;

    adc_port_io_ext_mux dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .stop_mode(stop_mode), .port_a_pins_in(a_pin),
        .port_a_pins_out(a_out), .port_a_pins_oe(a_oe),
        .port_b_pins_in(b_pin), .mux_addr_out(mux_addr_out),
        .cmd_start(cmd_start), .cmd_channel(cmd_channel),
        .ext_mux_mode(ext_mux_mode), .analog_route(analog_route),
        .analog_in_sel(analog_in_sel), .route_is_muxed(route_is_muxed));
    pin_model pins (.a_out(a_out), .a_oe(a_oe), .a_ext(a_ext),
        .b_ext(b_ext), .a_pin(a_pin), .b_pin(b_pin));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held through the edge that samples ack high; the ack
    // drops there, and the idle cycle after keeps it from toggling
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int i;
        @(negedge clk_sys);
        bus_sel = 1'b1;
        bus_wr = w;
        bus_addr = a;
        bus_wdata = d;
        for (i = 0; i < 4 && bus_ack !== 1'b1; i++)
            @(negedge clk_sys);
        if (i == 4) begin
            n_errors++;
            $display("CHECK FAILED bus_ack expected 1 seen %b", bus_ack);
            results();
        end
        q = bus_rdata;
        @(negedge clk_sys);
        bus_sel = 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string n);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    task automatic do_reset;
        @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, bus_sel, bus_wr, stop_mode, cmd_start} = 5'h00;
        {bus_addr, bus_wdata, cmd_channel} = 18'h0;
        a_ext = 8'h3c;
        b_ext = 8'h96;
        n_errors = 0;
        n_checks = 0;
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        // Low nibble out, high nibble in; no pins used as analog inputs
        wr(adc_port_pkg::OFF_PORT_A, 8'ha5);
        wr(adc_port_pkg::OFF_DIR_A, 8'h0f);
        chk("oe", 8'h0f, a_oe);
        rd(adc_port_pkg::OFF_DIR_A, 8'h0f, "dir");
        rd(adc_port_pkg::OFF_PORT_A, 8'h35, "port_a");
        rd(adc_port_pkg::OFF_PORT_A, 8'h35, "port_a");
        wr(adc_port_pkg::OFF_PORT_B, 8'h00);
        rd(adc_port_pkg::OFF_PORT_B, 8'h96, "port_b");
        rd(4'hf, 8'h00, "unmapped");
        do_reset();
        rd(adc_port_pkg::OFF_DIR_A, adc_port_pkg::DIR_A_RESET, "dir_rst");
        wr(adc_port_pkg::OFF_DIR_A, 8'hff);
        rd(adc_port_pkg::OFF_PORT_A, 8'ha5, "latch_kept");
        wr(adc_port_pkg::OFF_DIR_A, 8'h00);
        wr(adc_port_pkg::OFF_CTRL0, 8'h80);
        chk("mux_mode", 8'h01, {7'h0, ext_mux_mode});
        chk("muxed", 8'h01, {7'h0, route_is_muxed});
        for (c = 0; c < 32; c += 9) begin
            @(negedge clk_sys);
            cmd_start = 1'b1;
            cmd_channel = 6'(c);
            @(negedge clk_sys);
            cmd_start = 1'b0;
            chk("addr", 8'(c[3:1]), {5'h0, mux_addr_out});
            chk("route", {6'h0, c[4], c[0]},
                {6'h0, analog_route});
            chk("in_sel", 8'h01 << {c[4], c[0]},
                {4'h0, analog_in_sel});
            chk("oe_mux", 8'h07, a_oe);
            chk("pins_mux", 8'(c[3:1]), {5'h0, a_out[2:0]});
            rd(adc_port_pkg::OFF_PORT_A, 8'h38 | 8'(c[3:1]),
               "rd_mux");
            chk("addr_hold", 8'(c[3:1]),
                {5'h0, mux_addr_out});
        end
        stop_mode = 1'b1;
        wr(adc_port_pkg::OFF_DIR_A, 8'hff);
        rd(adc_port_pkg::OFF_DIR_A, 8'h00, "dir_stop");
        stop_mode = 1'b0;
        wr(adc_port_pkg::OFF_CTRL0, 8'h00);
        chk("mux_off", 8'h00, {7'h0, ext_mux_mode});
        chk("muxed_off", 8'h00, {7'h0, route_is_muxed});
        chk("oe_off", 8'h00, a_oe);
        results();
    end
endmodule
